/* pkg/fls_pkg.sv */
// package: register map, field layouts, modes and thresholds for line supervision
package fls_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;

    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h1;
    localparam logic [3:0] ADDR_MASK   = 4'h2;
    localparam logic [3:0] ADDR_LVOLT  = 4'h3;
    localparam logic [3:0] ADDR_LCURR  = 4'h4;
    localparam logic [3:0] ADDR_STATE  = 4'h5;
    localparam logic [3:0] ADDR_PHTHR  = 4'h6;

    // ctrl field positions
    localparam int C_PM_LO    = 0;  // 2 bits power mode
    localparam int C_ZFORCE   = 2;
    localparam int C_ISTEP    = 3;  // 0: 1.1 mA, 1: 3.3 mA
    localparam int C_ILIM     = 4;  // 0: 160 mA, 1: 60 mA
    localparam int C_MINI_LO  = 5;  // 2 bits: 10/12/14/16 mA
    localparam int C_DCSLOPE  = 7;  // 0: 50 ohm, 1: 800 ohm
    localparam int C_FS_LO    = 8;  // 2 bits full-scale level
    localparam int C_LB_LO    = 10; // 3 bits loopback select
    localparam int C_RVAL     = 13; // ring validation enable
    localparam logic [13:0] CTRL_RST = 14'h0000;

    // event bits
    localparam int EV_W     = 4;
    localparam int EV_POL   = 0;
    localparam int EV_OVC   = 1;
    localparam int EV_PHOFF = 2;
    localparam int EV_PHON  = 3;

    // zero-forcing window, volts
    localparam logic signed [7:0] ZF_LIM = 8'sh03;
    // current in 0.1 mA units
    localparam logic [11:0] ILIM_HI_DMA = 12'h640; // 160 mA
    localparam logic [11:0] ILIM_LO_DMA = 12'h258; // 60 mA
    localparam logic [11:0] MIN_I_BASE  = 12'h064; // 10 mA
    localparam logic [11:0] MIN_I_STEP  = 12'h014; // 2 mA per code
    localparam logic [11:0] STEP_FINE   = 12'h00b; // 1.1 mA
    localparam logic [11:0] STEP_COARSE = 12'h021; // 3.3 mA
    localparam logic [11:0] I_MAX_DMA   = 12'h4f6; // 127 mA
    localparam logic [7:0]  PH_THR_RST  = 8'h08;

    localparam logic [2:0] LB_MODES   = 3'h6;
    localparam logic [2:0] LB_NEEDPWR = 3'h3; // codes 3..6 need line-side power

    typedef enum logic [1:0] {
        PM_RESET = 2'b00,
        PM_NORMAL = 2'b01,
        PM_SLEEP = 2'b10,
        PM_PDOWN = 2'b11
    } fls_pm_t;

    typedef enum logic [1:0] {
        FS_DEFAULT = 2'b00,
        FS_RAISED = 2'b01,
        FS_ENHANCED = 2'b10,
        FS_RSVD = 2'b11
    } fls_fs_t;
endpackage

/* pkg/fls_evt_if.sv */
// interface: raw events from the measurement path to the interrupt unit
`timescale 1ns/1ps
interface fls_evt_if;
    import fls_pkg::*;
    logic [EV_W-1:0] pulse;
    logic            rd_clr;
    logic [EV_W-1:0] mask;
    logic [EV_W-1:0] status;
    logic            irq;
    modport src (output pulse, output rd_clr, output mask, input status, input irq);
    modport dst (input pulse, input rd_clr, input mask, output status, output irq);
endinterface

/* src/fls_irq.sv */
// module: sticky event flags, read-to-clear, masked level interrupt
`timescale 1ns/1ps
module fls_irq (
    input  wire logic clk_in,    // clock
    input  wire logic rst_in,    // sync reset, high
    fls_evt_if.dst    ev         // event bundle
);
    import fls_pkg::*;
    logic [EV_W-1:0] status_r;
    logic            irq_r;

    // set wins over the read clear so an event in the clearing cycle survives
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            status_r <= '0;
        end else begin
            status_r <= (ev.rd_clr ? '0 : status_r) | ev.pulse;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(((ev.rd_clr ? '0 : status_r) | ev.pulse) & ev.mask);
        end
    end

    assign ev.status = status_r;
    assign ev.irq    = irq_r;
endmodule

/* src/fls_meas.sv */
// module: loop current scaling into counts of the selected step
`timescale 1ns/1ps
module fls_meas (
    input  wire logic        clk_in,     // clock
    input  wire logic        rst_in,     // sync reset
    input  wire logic [11:0] i_dma_in,   // loop current, 0.1 mA units
    input  wire logic        coarse_in,  // step select
    output logic      [6:0]  count_out   // unsigned result
);
    import fls_pkg::*;
    logic [11:0] i_clip;
    logic [11:0] step;
    logic [11:0] q;

    // plain divide by a constant pair; sample rate is low so area beats latency
    always_comb begin
        i_clip = (i_dma_in > I_MAX_DMA) ? I_MAX_DMA : i_dma_in;
        step   = coarse_in ? STEP_COARSE : STEP_FINE;
        q      = i_clip / step;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            count_out <= '0;
        end else begin
            count_out <= q[6:0];
        end
    end
endmodule

/* src/fls_top.sv */
// module: office-line supervision, measurements, events and power modes
`timescale 1ns/1ps
// Function
// - line voltage reported signed, 1 V per count, -128 to 127.
// - optional zero-forcing sets readings from -3 to +3 volts to zero.
// - flag polarity reversal when consecutive samples have opposite nonzero signs.
// - loop current results only given while off-hook.
// - minimum loop current selectable 10, 12, 14 or 16 mA.
// - loop current unsigned 0 to 127 mA, step 1.1 or 3.3 mA.
// - over-current event when current exceeds 160 or 60 mA limit.
// - off-hook, significant current change signals parallel phone event.
// - on-hook, significant voltage drop signals parallel phone off-hook.
// - four power modes reset, normal, sleep, powerdown; normal fully operational.
// - reset mode keeps only the measurement path running; link, ring detect and loopback are off.
// - sleep keeps only the line-side link, ring detect, ring validation and wake-on-ring.
// - powerdown is nonfunctional; only a reset leaves it, returning to reset mode.
// - six loopback modes; four need the line side powered.
// - three full-scale levels: default, +3.2 dBm, +6.0 dBm.
// - DC termination slope selectable 50 or 800 ohms.
// - ring validation in normal mode; in sleep only with valid PCM clock.
module fls_top (
    input  wire logic                CLOCK_IN,        // 125 MHz clock
    input  wire logic                RESET_IN,        // sync reset, high
    input  wire logic [3:0]          ADDR_IN,         // register index
    input  wire logic [31:0]         WDATA_IN,        // write data
    input  wire logic                WR_IN,           // write strobe
    input  wire logic                RD_IN,           // read strobe
    output logic      [31:0]         RDATA_OUT,       // read data, next cycle
    output logic                     IRQ_OUT,         // level interrupt
    input  wire logic                SAMPLE_IN,       // new line sample strobe
    input  wire logic signed [8:0]   VOLT_IN,         // line voltage, volts
    input  wire logic [11:0]         CURR_IN,         // loop current, 0.1 mA
    input  wire logic                OFFHOOK_IN,      // port off-hook
    input  wire logic                LS_POWERED_IN,   // line side has power
    input  wire logic                PCLK_VALID_IN,   // external pcm clock good
    input  wire logic                RING_DET_IN,     // raw ring detect
    output logic                     LINK_EN_OUT,     // isolation link active
    output logic                     MEAS_EN_OUT,     // measurement path on
    output logic                     RING_EN_OUT,     // ring detect on
    output logic                     RVAL_EN_OUT,     // ring validation on
    output logic                     WAKE_OUT,        // wake-up on ring
    output logic      [2:0]          LOOPBACK_OUT,    // active loopback, 0 none
    output fls_pkg::fls_fs_t         FS_LEVEL_OUT,    // full-scale level
    output logic                     DC_SLOPE_OUT,    // 1: 800 ohm slope
    output logic      [1:0]          MIN_I_SEL_OUT    // min loop current code
);
    import fls_pkg::*;

    logic [13:0]         ctrl_r;
    logic [7:0]          ph_thr_r;
    logic [EV_W-1:0]     mask_r;
    fls_pm_t             pm_r;
    fls_pm_t             pm_nxt;
    logic signed [7:0]   volt_r;
    logic signed [7:0]   volt_sat;
    logic signed [7:0]   volt_nxt;
    logic signed [7:0]   prev_volt_r;
    logic [11:0]         prev_curr_r;
    logic                prev_valid_r;
    logic [6:0]          curr_cnt;
    logic [EV_W-1:0]     ev_pulse;
    logic [11:0]         i_limit;
    logic [11:0]         i_min;
    logic [11:0]         dcur;
    logic [8:0]          vdrop;
    logic                meas_on;
    logic [2:0]          lb_req;
    logic [31:0]         rdata_nxt;

    fls_evt_if evt ();

    function automatic logic sel(input logic [3:0] a, input logic [3:0] reg_a);
        sel = (a == reg_a);
    endfunction

    // ---------- control registers ----------
    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            ctrl_r <= CTRL_RST;
        end else if (WR_IN && sel(ADDR_IN, ADDR_CTRL)) begin
            ctrl_r <= WDATA_IN[13:0];
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            mask_r <= '0;
        end else if (WR_IN && sel(ADDR_IN, ADDR_MASK)) begin
            mask_r <= WDATA_IN[EV_W-1:0];
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            ph_thr_r <= PH_THR_RST;
        end else if (WR_IN && sel(ADDR_IN, ADDR_PHTHR)) begin
            ph_thr_r <= WDATA_IN[7:0];
        end
    end

    // ---------- power mode sequencing ----------
    // powerdown is sticky: writes cannot leave it, only the reset line can
    always_comb begin
        pm_nxt = pm_r;
        if (WR_IN && sel(ADDR_IN, ADDR_CTRL) && pm_r != PM_PDOWN) begin
            case (WDATA_IN[C_PM_LO +: 2])
                2'b00:   pm_nxt = PM_RESET;
                2'b01:   pm_nxt = PM_NORMAL;
                2'b10:   pm_nxt = PM_SLEEP;
                2'b11:   pm_nxt = PM_PDOWN;
                default: pm_nxt = pm_r;
            endcase
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            pm_r <= PM_RESET;
        end else begin
            pm_r <= pm_nxt;
        end
    end

    assign meas_on = (pm_r == PM_NORMAL) || (pm_r == PM_RESET);

    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            LINK_EN_OUT <= 1'b0;
            MEAS_EN_OUT <= 1'b0;
            RING_EN_OUT <= 1'b0;
            RVAL_EN_OUT <= 1'b0;
            WAKE_OUT    <= 1'b0;
        end else begin
            LINK_EN_OUT <= (pm_r == PM_NORMAL) || (pm_r == PM_SLEEP);
            MEAS_EN_OUT <= meas_on;
            RING_EN_OUT <= (pm_r == PM_NORMAL) || (pm_r == PM_SLEEP);
            RVAL_EN_OUT <= ctrl_r[C_RVAL] && ((pm_r == PM_NORMAL) ||
                           (pm_r == PM_SLEEP && PCLK_VALID_IN));
            WAKE_OUT    <= (pm_r == PM_SLEEP) && RING_DET_IN;
        end
    end

    // ---------- static settings out ----------
    always_comb begin
        lb_req = ctrl_r[C_LB_LO +: 3];
        if (lb_req > LB_MODES) begin
            lb_req = '0;
        end else if (lb_req >= LB_NEEDPWR && !LS_POWERED_IN) begin
            lb_req = '0;
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            LOOPBACK_OUT  <= '0;
            FS_LEVEL_OUT  <= FS_DEFAULT;
            DC_SLOPE_OUT  <= 1'b0;
            MIN_I_SEL_OUT <= '0;
        end else begin
            LOOPBACK_OUT  <= (pm_r == PM_NORMAL) ? lb_req : 3'h0;
            FS_LEVEL_OUT  <= (ctrl_r[C_FS_LO +: 2] == FS_RSVD) ? FS_DEFAULT
                             : fls_fs_t'(ctrl_r[C_FS_LO +: 2]);
            DC_SLOPE_OUT  <= ctrl_r[C_DCSLOPE];
            MIN_I_SEL_OUT <= ctrl_r[C_MINI_LO +: 2];
        end
    end

    // ---------- line voltage ----------
    always_comb begin
        if (VOLT_IN > 9'sd127) begin
            volt_sat = 8'sh7f;
        end else if (VOLT_IN < -9'sd128) begin
            volt_sat = 8'sh80;
        end else begin
            volt_sat = VOLT_IN[7:0];
        end
        volt_nxt = volt_sat;
        if (ctrl_r[C_ZFORCE] && volt_sat >= -ZF_LIM && volt_sat <= ZF_LIM) begin
            volt_nxt = '0;
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            volt_r <= '0;
        end else if (SAMPLE_IN && meas_on) begin
            volt_r <= volt_nxt;
        end
    end

    // ---------- loop current ----------
    fls_meas u_meas (
        .clk_in    (CLOCK_IN),
        .rst_in    (RESET_IN),
        .i_dma_in  (prev_curr_r),
        .coarse_in (ctrl_r[C_ISTEP]),
        .count_out (curr_cnt)
    );

    assign i_limit = ctrl_r[C_ILIM] ? ILIM_LO_DMA : ILIM_HI_DMA;
    assign i_min   = MIN_I_BASE + 12'(MIN_I_STEP * ctrl_r[C_MINI_LO +: 2]);
    assign dcur    = (CURR_IN > prev_curr_r) ? CURR_IN - prev_curr_r
                                             : prev_curr_r - CURR_IN;
    assign vdrop   = 9'(prev_volt_r) - 9'(volt_nxt);

    // ---------- event detection ----------
    // zero is neither sign, so a reversal through a zero sample is never flagged
    always_comb begin
        ev_pulse = '0;
        if (SAMPLE_IN && meas_on && prev_valid_r) begin
            if ((prev_volt_r > 0 && volt_nxt < 0) || (prev_volt_r < 0 && volt_nxt > 0)) begin
                ev_pulse[EV_POL] = 1'b1;
            end
            if (OFFHOOK_IN && CURR_IN > i_limit) begin
                ev_pulse[EV_OVC] = 1'b1;
            end
            if (OFFHOOK_IN && dcur > {4'h0, ph_thr_r}) begin
                if (CURR_IN < prev_curr_r) begin
                    ev_pulse[EV_PHOFF] = 1'b1;
                end else begin
                    ev_pulse[EV_PHON] = 1'b1;
                end
            end
            if (!OFFHOOK_IN && !vdrop[8] && vdrop[7:0] > ph_thr_r) begin
                ev_pulse[EV_PHOFF] = 1'b1;
            end
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            prev_volt_r  <= '0;
            prev_curr_r  <= '0;
            prev_valid_r <= 1'b0;
        end else if (SAMPLE_IN && meas_on) begin
            prev_volt_r  <= volt_nxt;
            prev_curr_r  <= CURR_IN;
            prev_valid_r <= 1'b1;
        end
    end

    assign evt.pulse  = ev_pulse;
    assign evt.mask   = mask_r;
    assign evt.rd_clr = RD_IN && sel(ADDR_IN, ADDR_STATUS);

    fls_irq u_irq (
        .clk_in (CLOCK_IN),
        .rst_in (RESET_IN),
        .ev     (evt.dst)
    );

    // ---------- read port ----------
    always_comb begin
        rdata_nxt = '0;
        case (ADDR_IN)
            ADDR_CTRL:   rdata_nxt = {18'h0, ctrl_r[13:2], pm_r};
            ADDR_STATUS: rdata_nxt = {28'h0, evt.status};
            ADDR_MASK:   rdata_nxt = {28'h0, mask_r};
            ADDR_LVOLT:  rdata_nxt = {{24{volt_r[7]}}, volt_r};
            ADDR_LCURR:  begin
                // below the minimum operating current the reading is invalid
                if (OFFHOOK_IN && prev_curr_r >= i_min) begin
                    rdata_nxt = {25'h0, curr_cnt};
                end
            end
            ADDR_STATE:  rdata_nxt = {28'h0, LS_POWERED_IN, OFFHOOK_IN, pm_r};
            ADDR_PHTHR:  rdata_nxt = {24'h0, ph_thr_r};
            default:     rdata_nxt = '0;
        endcase
    end

    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            RDATA_OUT <= '0;
        end else begin
            RDATA_OUT <= RD_IN ? rdata_nxt : 32'h0;
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            IRQ_OUT <= 1'b0;
        end else begin
            IRQ_OUT <= evt.irq;
        end
    end
endmodule

/* tb/fls_top_properties.sv */
// checker: port-level properties of the line supervision top
`timescale 1ns/1ps
module fls_top_properties
    import fls_pkg::*;
(
    input wire logic        CLOCK_IN,      // clock
    input wire logic        RESET_IN,      // sync reset, high
    input wire logic [3:0]  ADDR_IN,       // register index
    input wire logic [31:0] WDATA_IN,      // write data
    input wire logic        WR_IN,         // write strobe
    input wire logic        RD_IN,         // read strobe
    input wire logic [31:0] RDATA_OUT,     // read data
    input wire logic        IRQ_OUT,       // interrupt
    input wire logic        SAMPLE_IN,     // sample strobe
    input wire logic        LS_POWERED_IN, // line side powered
    input wire logic        PCLK_VALID_IN, // pcm clock good
    input wire logic        LINK_EN_OUT,   // link on
    input wire logic        MEAS_EN_OUT,   // measurement on
    input wire logic        RING_EN_OUT,   // ring detect on
    input wire logic        RVAL_EN_OUT,   // ring validation on
    input wire logic        WAKE_OUT,      // wake on ring
    input wire logic [2:0]  LOOPBACK_OUT,  // loopback code
    input wire fls_fs_t     FS_LEVEL_OUT,  // full scale
    input wire logic        DC_SLOPE_OUT,  // slope select
    input wire logic [1:0]  MIN_I_SEL_OUT  // min current code
);
    logic [13:0] ctrl_r;
    logic [1:0]  age_r;
    wire  [1:0]  pm = ctrl_r[1:0];
    wire  [2:0]  lb = ctrl_r[12:10];
    wire         mask_wr = WR_IN && ADDR_IN == ADDR_MASK;
    wire         st_rd = RD_IN && ADDR_IN == ADDR_STATUS;
    wire  [2:0]  lb_exp = (pm == 2'h1 && lb != 3'h0 && lb != 3'h7 &&
                           (lb < 3'h3 || LS_POWERED_IN)) ? lb : 3'h0;
    // mirror of the control register; the mode field is frozen in powerdown
    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            ctrl_r <= 14'h0000;
        end else if (WR_IN && ADDR_IN == ADDR_CTRL) begin
            ctrl_r <= {WDATA_IN[13:2], (pm == 2'h3) ? 2'h3 : WDATA_IN[1:0]};
        end
    end
    // enable and setting outputs are only judged once a control change has had time to land
    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN || (WR_IN && ADDR_IN == ADDR_CTRL)) begin
            age_r <= 2'h0;
        end else if (age_r != 2'h3) begin
            age_r <= age_r + 2'h1;
        end
    end
    default clocking @(posedge CLOCK_IN); endclocking
    default disable iff (RESET_IN);
    a_rdata_quiet: assert property (!$past(RD_IN) |-> RDATA_OUT == 32'h0)
        else $error("read data outside the answer cycle");
    a_link_mode: assert property (age_r == 2'h3 |-> LINK_EN_OUT == (pm == 2'h1 || pm == 2'h2))
        else $error("link enable wrong for mode");
    a_meas_mode: assert property (age_r == 2'h3 |-> MEAS_EN_OUT == (pm == 2'h0 || pm == 2'h1))
        else $error("measurement enable wrong for mode");
    a_pdown_quiet: assert property (age_r == 2'h3 && pm == 2'h3 |->
        !(LINK_EN_OUT || MEAS_EN_OUT || RING_EN_OUT || RVAL_EN_OUT || WAKE_OUT))
        else $error("powerdown not quiet");
    a_ring_sleep: assert property (age_r == 2'h3 && pm == 2'h2 |-> RING_EN_OUT && !MEAS_EN_OUT)
        else $error("sleep ring detect wrong");
    a_rval_gate: assert property (age_r == 2'h3 && $stable(PCLK_VALID_IN) |-> RVAL_EN_OUT ==
        (ctrl_r[13] && (pm == 2'h1 || (pm == 2'h2 && PCLK_VALID_IN))))
        else $error("ring validation enable wrong");
    a_loop_sel: assert property (age_r == 2'h3 && $stable(LS_POWERED_IN) |-> LOOPBACK_OUT == lb_exp)
        else $error("loopback selection wrong");
    a_line_cfg: assert property (age_r == 2'h3 && pm != 2'h3 |-> DC_SLOPE_OUT == ctrl_r[7] &&
        MIN_I_SEL_OUT == ctrl_r[6:5] && FS_LEVEL_OUT == ((ctrl_r[9:8] == 2'h3) ? 2'h0 : ctrl_r[9:8]))
        else $error("line configuration outputs wrong");
    a_irq_cause: assert property ($rose(IRQ_OUT) |->
        $past(SAMPLE_IN, 2) || $past(SAMPLE_IN, 3) || $past(mask_wr, 2) || $past(mask_wr, 3))
        else $error("interrupt rose without cause");
    a_irq_clear: assert property ($fell(IRQ_OUT) |->
        $past(st_rd) || $past(st_rd, 2) || $past(mask_wr, 2) || $past(mask_wr, 3))
        else $error("interrupt fell without clear");
    c_irq: cover property (SAMPLE_IN ##[1:3] $rose(IRQ_OUT));
    c_pdown: cover property (age_r == 2'h3 && pm == 2'h3);
    c_loop: cover property (LOOPBACK_OUT == 3'h6);
endmodule
bind fls_top fls_top_properties fls_top_properties_inst (
    .CLOCK_IN(CLOCK_IN), .RESET_IN(RESET_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN),
    .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT), .IRQ_OUT(IRQ_OUT),
    .SAMPLE_IN(SAMPLE_IN), .LS_POWERED_IN(LS_POWERED_IN), .PCLK_VALID_IN(PCLK_VALID_IN),
    .LINK_EN_OUT(LINK_EN_OUT), .MEAS_EN_OUT(MEAS_EN_OUT), .RING_EN_OUT(RING_EN_OUT),
    .RVAL_EN_OUT(RVAL_EN_OUT), .WAKE_OUT(WAKE_OUT), .LOOPBACK_OUT(LOOPBACK_OUT),
    .FS_LEVEL_OUT(FS_LEVEL_OUT), .DC_SLOPE_OUT(DC_SLOPE_OUT), .MIN_I_SEL_OUT(MIN_I_SEL_OUT));

/* tb/fls_line_model.sv */
// model: isolated line-side device delivering voltage and current samples
`timescale 1ns/1ps
module fls_line_model (
    input  wire logic              clk_in,     // clock
    input  wire logic              req_in,     // bench asks for one sample
    input  wire logic signed [8:0] volt_in,    // voltage to deliver
    input  wire logic [11:0]       curr_in,    // current to deliver
    output logic                   sample_out, // sample strobe
    output logic signed [8:0]      volt_out,   // line voltage
    output logic [11:0]            curr_out    // loop current
);
    initial begin
        sample_out = 1'b0;
        volt_out = 9'sh000;
        curr_out = 12'h000;
    end
    // outside the strobe the lines toggle so a stale value is never trusted
    always @(posedge clk_in) begin
        sample_out <= req_in;
        volt_out <= req_in ? volt_in : ~volt_out;
        curr_out <= req_in ? curr_in : ~curr_out;
    end
endmodule

/* tb/test_fxo_line_supervision.sv */
// testbench: line supervision top with line-side model
`timescale 1ns/1ps
module test_fxo_line_supervision;
    import fls_pkg::*;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic [3:0]        addr = 4'h0;
    logic [31:0]       wdata = 32'h0;
    logic              wr = 1'b0;
    logic              rd = 1'b0;
    logic              req = 1'b0;
    logic signed [8:0] vset = 9'sh000;
    logic [11:0]       cset = 12'h000;
    logic              hook = 1'b1;
    logic              lspwr = 1'b1;
    logic              pclk = 1'b1;
    logic              ring = 1'b0;
    logic              smp;
    logic signed [8:0] volt;
    logic [11:0]       curr;
    logic [31:0]       rdata;
    logic              irq;
    logic [31:0]       v;
    int                n_mismatch = 0;
    int                compares = 0;

    always #4 clk = ~clk;

    fls_line_model fls_line_model_inst (.clk_in(clk), .req_in(req), .volt_in(vset),
        .curr_in(cset), .sample_out(smp), .volt_out(volt), .curr_out(curr));
    fls_top fls_top_inst (.CLOCK_IN(clk), .RESET_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata),
        .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .IRQ_OUT(irq), .SAMPLE_IN(smp),
        .VOLT_IN(volt), .CURR_IN(curr), .OFFHOOK_IN(hook), .LS_POWERED_IN(lspwr),
        .PCLK_VALID_IN(pclk), .RING_DET_IN(ring), .LINK_EN_OUT(), .MEAS_EN_OUT(),
        .RING_EN_OUT(), .RVAL_EN_OUT(), .WAKE_OUT(), .LOOPBACK_OUT(), .FS_LEVEL_OUT(),
        .DC_SLOPE_OUT(), .MIN_I_SEL_OUT());

    task automatic finish_test;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // answer stands only in the cycle after the strobe, so sample mid-cycle
    task automatic rreg(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
        rreg(a, v);
        chk(v, exp);
    endtask
    task automatic line(input logic signed [8:0] vv, input logic [11:0] cc);
        @(posedge clk);
        req <= 1'b1;
        vset <= vv;
        cset <= cc;
        @(posedge clk);
        req <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic do_reset;
        @(posedge clk);
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
    endtask

    task automatic t_regs;
        rchk(ADDR_CTRL, 32'h0);
        rchk(ADDR_MASK, 32'h0);
        rchk(ADDR_PHTHR, 32'h8);
        rchk(ADDR_STATE, 32'h8);
        wreg(4'hf, 32'hffffffff);
        rchk(4'hf, 32'h0);
    endtask
    task automatic t_volt;
        wreg(ADDR_CTRL, 32'h1);
        line(9'sh014, 12'h0);
        line(9'sh180, 12'h0);
        rchk(ADDR_LVOLT, 32'hffffff80);
        rchk(ADDR_STATUS, 32'h1);
        line(9'sh07f, 12'h0);
        rchk(ADDR_LVOLT, 32'h7f);
        rchk(ADDR_STATUS, 32'h1);
        wreg(ADDR_CTRL, 32'h5);
        line(9'sh003, 12'h0);
        rchk(ADDR_LVOLT, 32'h0);
        line(9'sh1fd, 12'h0);
        rchk(ADDR_LVOLT, 32'h0);
        rchk(ADDR_STATUS, 32'h0);
    endtask
    task automatic t_phone;
        wreg(ADDR_CTRL, 32'h1);
        hook <= 1'b0;
        line(9'sh032, 12'h0);
        rreg(ADDR_STATUS, v);
        line(9'sh029, 12'h0);
        rchk(ADDR_STATUS, 32'h4);
        line(9'sh021, 12'h0);
        rchk(ADDR_STATUS, 32'h0);
        hook <= 1'b1;
        line(9'sh021, 12'h1f4);
        rreg(ADDR_STATUS, v);
        line(9'sh021, 12'h1eb);
        rchk(ADDR_STATUS, 32'h4);
        line(9'sh021, 12'h1f4);
        rchk(ADDR_STATUS, 32'h8);
        line(9'sh021, 12'h1fc);
        rchk(ADDR_STATUS, 32'h0);
    endtask
    task automatic t_curr;
        line(9'sh021, 12'h3de);
        rchk(ADDR_LCURR, 32'd90);
        wreg(ADDR_CTRL, 32'h9);
        line(9'sh021, 12'h3de);
        rchk(ADDR_LCURR, 32'd30);
        wreg(ADDR_CTRL, 32'h61);
        line(9'sh021, 12'h09a);
        rchk(ADDR_LCURR, 32'd0);
        line(9'sh021, 12'h0a5);
        rchk(ADDR_LCURR, 32'd15);
        hook <= 1'b0;
        line(9'sh021, 12'h3de);
        rchk(ADDR_LCURR, 32'd0);
        hook <= 1'b1;
        // a wide threshold keeps the one-step current moves free of handset events
        wreg(ADDR_PHTHR, 32'hff);
        for (int i = 0; i < 2; i++) begin
            wreg(ADDR_CTRL, (i == 0) ? 32'h1 : 32'h11);
            line(9'sh021, ((i == 0) ? 12'h640 : 12'h258) + 12'h1);
            rreg(ADDR_STATUS, v);
            line(9'sh021, (i == 0) ? 12'h640 : 12'h258);
            rchk(ADDR_STATUS, 32'h0);
            line(9'sh021, ((i == 0) ? 12'h640 : 12'h258) + 12'h1);
            rchk(ADDR_STATUS, 32'h2);
        end
    endtask
    task automatic t_irq;
        wreg(ADDR_MASK, 32'h1);
        line(9'sh014, 12'h259);
        rreg(ADDR_STATUS, v);
        line(9'sh1ec, 12'h259);
        chk(irq, 1'b1);
        rchk(ADDR_STATUS, 32'h3);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        wreg(ADDR_MASK, 32'h0);
        line(9'sh014, 12'h259);
        chk(irq, 1'b0);
        rchk(ADDR_STATUS, 32'h3);
    endtask
    task automatic t_modes;
        for (int i = 0; i < 8; i++) begin
            wreg(ADDR_CTRL, 32'h1 | (i << 10) | ((i % 4) << 8) | ((i % 2) << 7) | ((i % 4) << 5));
            lspwr <= i[1];
            repeat (5) @(posedge clk);
        end
        wreg(ADDR_CTRL, 32'h2002);
        rchk(ADDR_STATE, 32'he);
        ring <= 1'b1;
        repeat (5) @(posedge clk);
        pclk <= 1'b0;
        line(9'sh1ec, 12'h259);
        rchk(ADDR_STATUS, 32'h0);
        pclk <= 1'b1;
        ring <= 1'b0;
        wreg(ADDR_CTRL, 32'h0);
        rchk(ADDR_STATE, 32'hc);
        wreg(ADDR_CTRL, 32'h3);
        repeat (5) @(posedge clk);
        wreg(ADDR_CTRL, 32'h1);
        rchk(ADDR_STATE, 32'hf);
        do_reset;
        rchk(ADDR_STATE, 32'hc);
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        $display("wrong value at %0t: run timed out", $time);
        finish_test;
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        hook <= 1'b0;
        t_regs;
        hook <= 1'b1;
        t_volt;
        t_phone;
        t_curr;
        t_irq;
        t_modes;
        finish_test;
    end
endmodule
